// File: rtl/viu_pkg.sv
// vectored interrupt unit: shared constants and carrier types
package viu_pkg;
  localparam int NUM_SRC = 5;
  localparam int VEC_W = 11;
  localparam int PC_W = 11;
  // source index order is priority order, lowest index wins
  localparam int SRC_TB = 0;
  localparam int SRC_TA = 1;
  localparam int SRC_TB1 = 2;
  localparam int SRC_SA = 3;
  localparam int SRC_SB = 4;
  localparam logic [VEC_W-1:0] VEC_TIMEBASE = 11'h004;
  localparam logic [VEC_W-1:0] VEC_TIMER_A = 11'h008;
  localparam logic [VEC_W-1:0] VEC_TIMER_B = 11'h00C;
  localparam logic [VEC_W-1:0] VEC_SERIAL_A = 11'h010;
  localparam logic [VEC_W-1:0] VEC_SERIAL_B = 11'h014;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 5'h00;
  localparam logic GIE_RESET = 1'b0;

  // per-source request events from the peripherals
  typedef struct packed {
    logic timebase_ovf;
    logic timer_a_ovf;
    logic timer_b_ovf;
    logic [1:0] spi_byte_done;
    logic [1:0] i2c_addr_match;
    logic [1:0] i2c_byte_done;
  } viu_events_t;

  // enables as held in the two control registers
  typedef struct packed {
    logic global_irq_enable;
    logic timebase_irq_enable;
    logic timer_a_irq_enable;
    logic timer_b_irq_enable;
    logic [1:0] serial_ab_irq_enable;
    logic [1:0] serial_module_enable;
    logic [1:0] serial_i2c_mode;
  } viu_enables_t;

  // interrupt entry request to the program sequencer
  typedef struct packed {
    logic take;
    logic [VEC_W-1:0] vector;
    logic [PC_W-1:0] push_pc;
  } viu_entry_t;
endpackage : viu_pkg

// File: rtl/viu_prio.sv
// vectored interrupt unit: fixed priority pick among qualified requests
`timescale 1ns/100ps
`default_nettype none
module viu_prio #(
  parameter int N = 5
) (
  input wire logic [N-1:0] req_in,
  output logic any_out,
  output logic [N-1:0] grant_out
);
  initial
  begin
    if (N < 1) $error("viu_prio needs at least one source");
  end
  always_comb
  begin
    any_out = |req_in;
    grant_out = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_in[i]) grant_out = '0;
      if (req_in[i]) grant_out[i] = 1'b1;
    end
  end
endmodule : viu_prio
`default_nettype wire

// File: rtl/viu_top.sv
// vectored interrupt unit: flags, enables, sampling, entry and return
// Contract
// - requests between two phase-two pulses are serviced at the second pulse
// - priority: time base, timer a, timer b, serial a, serial b
// - time base request branches to vector 04H when enabled, stack not full
// - time base flag set on overflow; needs its own enable to be taken
// - time base entry clears its flag and the global enable
// - each timer sets its flag on overflow and needs its own enable
// - timer a to 08H, timer b to 0CH when enabled, stack not full
// - timer entry clears that timer flag and the global enable
// - spi interrupt needs global, module interrupt and module enable bits
// - spi flag set each time eight bits are transferred
// - serial a branches to vector 10H when enabled, stack not full
// - serial b branches to vector 14H when enabled, stack not full
// - serial entry clears that module flag and the global enable
// - i2c interrupt needs the module interrupt enable set
// - i2c flag set on address match or data byte completion
// - a set flag holds, even when disabled, until serviced or cleared
// - any set flag wakes the core from power-down
// - entry pushes only the program counter
// - no entry while the stack is full
// - global enable cleared blocks every source
// - return from interrupt pops the saved program counter
`timescale 1ns/100ps
`default_nettype none
module viu_top
  import viu_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic phase_two_pulse_in,
  input wire viu_pkg::viu_events_t events_in,
  input wire viu_pkg::viu_enables_t enables_in,
  input wire logic enables_wr_in,
  input wire logic [viu_pkg::NUM_SRC-1:0] flag_clr_in,
  input wire logic [viu_pkg::NUM_SRC-1:0] flag_set_in,
  input wire logic [viu_pkg::PC_W-1:0] pc_in,
  input wire logic stack_full_in,
  input wire logic return_from_irq_in,
  input wire logic [viu_pkg::PC_W-1:0] pop_pc_in,
  output logic [viu_pkg::NUM_SRC-1:0] irq_flags_out,
  output logic global_irq_enable_out,
  output viu_pkg::viu_entry_t entry_out,
  output logic pc_load_out,
  output logic [viu_pkg::PC_W-1:0] pc_load_value_out,
  output logic wake_out
);
  import viu_pkg::*;

  initial
  begin
    if (STACK_DEPTH < 1) $error("viu_top needs a stack of at least one level");
  end

  typedef struct packed {
    logic [NUM_SRC-1:0] flags;
    logic gie;
    logic [NUM_SRC-1:0] en;
    logic [1:0] sim_en;
    logic prev_p2;
    viu_entry_t entry;
    logic pc_load;
    logic [PC_W-1:0] pc_val;
    logic wake;
  } viu_state_t;

  viu_state_t s_q;
  viu_state_t s_d;
  logic [NUM_SRC-1:0] qual;
  logic [NUM_SRC-1:0] grant;
  logic any_req;
  logic [NUM_SRC-1:0] ev;
  logic p2_rise;
  logic take_ok;
  logic [VEC_W-1:0] vec;

  // phase pulse comes from core logic on the same clock, so no synchroniser
  assign p2_rise = phase_two_pulse_in & ~s_q.prev_p2;
  // a pc load still in flight leaves pc_in stale, so that pulse is skipped
  assign take_ok = p2_rise & ~s_q.pc_load & ~return_from_irq_in;

  always_comb
  begin
    ev[SRC_TB] = events_in.timebase_ovf;
    ev[SRC_TA] = events_in.timer_a_ovf;
    ev[SRC_TB1] = events_in.timer_b_ovf;
    for (int m = 0; m < 2; m++)
    begin
      // mode picks which event source feeds the flag
      ev[SRC_SA + m] = s_q.sim_en[m] & (enables_in.serial_i2c_mode[m] ?
        (events_in.i2c_addr_match[m] | events_in.i2c_byte_done[m]) :
        events_in.spi_byte_done[m]);
    end
  end

  always_comb
  begin
    qual = s_q.flags & s_q.en;
    // spi path also needs the module enable; i2c path does not
    for (int m = 0; m < 2; m++)
    begin
      if (!enables_in.serial_i2c_mode[m] && !s_q.sim_en[m]) qual[SRC_SA + m] = 1'b0;
    end
    if (!s_q.gie || stack_full_in) qual = '0;
  end

  viu_prio #(
    .N(NUM_SRC)
  ) u_prio (
    .req_in(qual),
    .any_out(any_req),
    .grant_out(grant)
  );

  always_comb
  begin
    vec = VEC_TIMEBASE;
    case (1'b1)
      grant[SRC_TB]: vec = VEC_TIMEBASE;
      grant[SRC_TA]: vec = VEC_TIMER_A;
      grant[SRC_TB1]: vec = VEC_TIMER_B;
      grant[SRC_SA]: vec = VEC_SERIAL_A;
      grant[SRC_SB]: vec = VEC_SERIAL_B;
      default: vec = VEC_TIMEBASE;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.prev_p2 = phase_two_pulse_in;
    s_d.entry.take = 1'b0;
    s_d.pc_load = 1'b0;
    if (enables_wr_in)
    begin
      s_d.gie = enables_in.global_irq_enable;
      s_d.en = {enables_in.serial_ab_irq_enable[1], enables_in.serial_ab_irq_enable[0],
        enables_in.timer_b_irq_enable, enables_in.timer_a_irq_enable, enables_in.timebase_irq_enable};
      s_d.sim_en = enables_in.serial_module_enable;
    end
    // software clear first, hardware set after so the set wins
    s_d.flags = s_q.flags & ~flag_clr_in;
    // sampling: requests pending since the last pulse are taken on this one
    if (take_ok)
    begin
      if (any_req)
      begin
        s_d.entry.take = 1'b1;
        s_d.entry.vector = vec;
        s_d.entry.push_pc = pc_in;
        s_d.pc_load = 1'b1;
        s_d.pc_val = vec;
        s_d.flags = s_d.flags & ~grant;
        s_d.gie = 1'b0;
      end
    end
    if (return_from_irq_in)
    begin
      s_d.pc_load = 1'b1;
      s_d.pc_val = pop_pc_in;
    end
    s_d.flags = s_d.flags | ev | flag_set_in;
    s_d.wake = |s_d.flags;
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
      s_q.flags <= FLAGS_RESET;
      s_q.gie <= GIE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign irq_flags_out = s_q.flags;
  assign global_irq_enable_out = s_q.gie;
  assign entry_out = s_q.entry;
  assign pc_load_out = s_q.pc_load;
  assign pc_load_value_out = s_q.pc_val;
  assign wake_out = s_q.wake;

  a_entry_clears_gie: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.entry.take |-> !s_q.gie) else $error("global enable still set after entry");
  a_no_entry_full: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(s_q.entry.take) |-> $past(!stack_full_in)) else $error("entry taken with full stack");
  a_no_entry_gie: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.entry.take |-> $past(s_q.gie)) else $error("entry taken with global enable off");
  a_entry_on_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.entry.take |-> $past(p2_rise)) else $error("entry not on a phase pulse");
  a_tb_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_TB]) |=> (s_q.entry.vector == VEC_TIMEBASE))
    else $error("time base vector wrong");
  a_prio_order: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_TA] && !qual[SRC_TB]) |=> (s_q.entry.vector == VEC_TIMER_A))
    else $error("timer a priority wrong");
  a_flag_holds: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_q.flags[SRC_SB] && !flag_clr_in[SRC_SB] && !(take_ok && grant[SRC_SB]))
    |=> s_q.flags[SRC_SB]) else $error("serial b flag dropped");
  a_wake_follows: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 (wake_out == (|s_q.flags))) else $error("wake does not follow flags");
  a_return_from_irq_pops: assert property (@(posedge clk_in) disable iff (rst_in)
    return_from_irq_in |=> (pc_load_out && pc_load_value_out == $past(pop_pc_in)))
    else $error("return did not load popped pc");

  // vectors for the lower priority sources
  a_tb1_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_TB1] && qual[SRC_TA:SRC_TB] == 2'h0)
    |=> (s_q.entry.vector == VEC_TIMER_B))
    else $error("timer b vector wrong");
  a_sa_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_SA] && qual[SRC_TB1:SRC_TB] == 3'h0)
    |=> (s_q.entry.vector == VEC_SERIAL_A))
    else $error("serial a vector wrong");
  a_sb_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual == 5'h10)
    |=> (s_q.entry.vector == VEC_SERIAL_B))
    else $error("serial b vector wrong");
  a_load_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.entry.take
    |-> (s_q.pc_load && s_q.pc_val == s_q.entry.vector))
    else $error("pc not loaded with vector");
  a_push_pc: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && any_req)
    |=> (s_q.entry.push_pc == $past(pc_in)))
    else $error("pushed pc wrong");
  a_take_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    s_q.entry.take
    |=> !s_q.entry.take)
    else $error("entry held two cycles");
  a_pend_taken: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && any_req)
    |=> s_q.entry.take)
    else $error("pending request not taken");

  // hardware clears only the serviced flag
  a_tb_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_TB] && !ev[SRC_TB] && !flag_set_in[SRC_TB])
    |=> !s_q.flags[SRC_TB])
    else $error("time base flag not cleared");
  a_ta_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_TA] && !qual[SRC_TB] && !ev[SRC_TA] && !flag_set_in[SRC_TA])
    |=> !s_q.flags[SRC_TA])
    else $error("timer a flag not cleared");
  a_sa_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (take_ok && qual[SRC_SA] && qual[SRC_TB1:SRC_TB] == 3'h0 && !ev[SRC_SA] && !flag_set_in[SRC_SA])
    |=> !s_q.flags[SRC_SA])
    else $error("serial a flag not cleared");

  // timer events raise their flags whatever the enables say; serial events need the module enable
  a_tb_set: assert property (@(posedge clk_in) disable iff (rst_in)
    events_in.timebase_ovf
    |=> s_q.flags[SRC_TB])
    else $error("time base flag not set");
  a_ta_set: assert property (@(posedge clk_in) disable iff (rst_in)
    events_in.timer_a_ovf
    |=> s_q.flags[SRC_TA])
    else $error("timer a flag not set");
  a_tb1_set: assert property (@(posedge clk_in) disable iff (rst_in)
    events_in.timer_b_ovf
    |=> s_q.flags[SRC_TB1])
    else $error("timer b flag not set");
  a_spi_set: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_q.sim_en[0] && !enables_in.serial_i2c_mode[0] && events_in.spi_byte_done[0])
    |=> s_q.flags[SRC_SA])
    else $error("spi byte did not set flag");
  a_i2c_set: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_q.sim_en[1] && enables_in.serial_i2c_mode[1] && (events_in.i2c_addr_match[1] || events_in.i2c_byte_done[1]))
    |=> s_q.flags[SRC_SB])
    else $error("i2c event did not set flag");
  a_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    (flag_set_in[SRC_TA] && flag_clr_in[SRC_TA])
    |=> s_q.flags[SRC_TA])
    else $error("clear beat a set");
  a_soft_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (flag_clr_in[SRC_TB1] && !ev[SRC_TB1] && !flag_set_in[SRC_TB1])
    |=> !s_q.flags[SRC_TB1])
    else $error("software clear ignored");

  // qualification and blocking
  a_gie_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
    !s_q.gie
    |=> !s_q.entry.take)
    else $error("entry with global enable off");
  a_full_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
    stack_full_in
    |=> !s_q.entry.take)
    else $error("entry with full stack");
  a_spi_mod_en: assert property (@(posedge clk_in) disable iff (rst_in)
    (!enables_in.serial_i2c_mode[0] && !s_q.sim_en[0])
    |-> !qual[SRC_SA])
    else $error("spi qualified without module enable");
  a_i2c_irq_en: assert property (@(posedge clk_in) disable iff (rst_in)
    !s_q.en[SRC_SA]
    |-> !qual[SRC_SA])
    else $error("serial qualified without its enable");
  a_ta_irq_en: assert property (@(posedge clk_in) disable iff (rst_in)
    !s_q.en[SRC_TA]
    |-> !qual[SRC_TA])
    else $error("timer qualified without its enable");
  a_wake_any: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_q.flags != 5'h00)
    |-> wake_out)
    else $error("no wake with a flag set");
endmodule : viu_top
`default_nettype wire

// File: sim/viu_core_model.sv
// core sequencer and stack model facing the interrupt unit
`timescale 1ns/100ps
`default_nettype none
module viu_core_model
  import viu_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire viu_pkg::viu_entry_t entry_in,
  input wire logic pc_load_in,
  input wire logic [viu_pkg::PC_W-1:0] pc_load_value_in,
  input wire logic ret_req_in,
  output logic [viu_pkg::PC_W-1:0] pc_out,
  output logic stack_full_out,
  output logic return_out,
  output logic [viu_pkg::PC_W-1:0] pop_pc_out
);
  logic [PC_W-1:0] stk_q [8];
  int sp_q;
  assign stack_full_out = sp_q == DEPTH;
  // junk outside a return, never a stale pc
  assign pop_pc_out = return_out ? stk_q[sp_q-1] : ~pc_out;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sp_q <= 0;
      pc_out <= 11'h123;
      return_out <= 1'b0;
    end
    else
    begin
      return_out <= ret_req_in && sp_q > 0;
      if (pc_load_in)
        pc_out <= pc_load_value_in;
      if (entry_in.take)
      begin
        stk_q[sp_q] <= entry_in.push_pc;
        sp_q <= sp_q + 1;
      end
      else if (return_out)
        sp_q <= sp_q - 1;
    end
  end
endmodule : viu_core_model
`default_nettype wire

// File: sim/viu_top_bench.sv
// self-checking bench for the vectored interrupt unit
`timescale 1ns/100ps
`default_nettype none
module viu_top_bench;
  import viu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic p2 = 1'b0;
  logic en_wr = 1'b0;
  logic ret_req = 1'b0;
  logic [1:0] ph = 2'h0;
  viu_events_t ev = '0;
  viu_enables_t en = '0;
  logic [NUM_SRC-1:0] fclr = '0;
  logic [NUM_SRC-1:0] fset = '0;
  logic [PC_W-1:0] pc, pop_pc, ldv, pcb;
  logic full, ret, ld, gie, wake;
  logic [NUM_SRC-1:0] flags;
  viu_entry_t ent;
  int failures = 0;
  int num_checks = 0;
  logic [VEC_W-1:0] vt [7] = '{VEC_TIMEBASE, VEC_TIMER_A, VEC_TIMER_B, VEC_SERIAL_A, VEC_SERIAL_B,
    VEC_SERIAL_B, VEC_SERIAL_A};
  viu_top i_viu_top (.clk_in(clk), .rst_in(rst), .phase_two_pulse_in(p2), .events_in(ev), .enables_in(en),
    .enables_wr_in(en_wr), .flag_clr_in(fclr), .flag_set_in(fset), .pc_in(pc), .stack_full_in(full),
    .return_from_irq_in(ret), .pop_pc_in(pop_pc), .irq_flags_out(flags), .global_irq_enable_out(gie),
    .entry_out(ent), .pc_load_out(ld), .pc_load_value_out(ldv), .wake_out(wake));
  viu_core_model #(.DEPTH(2)) i_viu_core_model (.clk_in(clk), .rst_in(rst), .entry_in(ent), .pc_load_in(ld),
    .pc_load_value_in(ldv), .ret_req_in(ret_req), .pc_out(pc), .stack_full_out(full), .return_out(ret),
    .pop_pc_out(pop_pc));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    ph <= ph + 2'h1;
    p2 <= ph == 2'h3;
  end
  task automatic results;
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input viu_enables_t e);
    @(posedge clk);
    en <= e;
    en_wr <= 1'b1;
    @(posedge clk);
    en_wr <= 1'b0;
  endtask : wr
  task automatic fire(input viu_events_t e, input logic [4:0] s, input logic [4:0] c);
    @(posedge clk);
    ev <= e;
    fset <= s;
    fclr <= c;
    @(posedge clk);
    ev <= '0;
    fset <= '0;
    fclr <= '0;
  endtask : fire
  task automatic take(input logic [VEC_W-1:0] v, input logic [PC_W-1:0] p, input int f);
    for (int i = 0; i < 40 && ent.take !== 1'b1; i++)
      tick();
    chk({ent.take, ld, flags[f], gie}, 4'hC);
    chk(ent.vector, v);
    chk(ldv, v);
    chk(ent.push_pc, p);
  endtask : take
  task automatic quiet;
    repeat (20)
    begin
      tick();
      chk(ent.take, 1'b0);
    end
  endtask : quiet
  task automatic pop(input logic [PC_W-1:0] p);
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    for (int i = 0; i < 10 && ld !== 1'b1; i++)
      tick();
    chk(ldv, p);
  endtask : pop
  function automatic viu_events_t evk(input int k);
    viu_events_t e;
    e = '0;
    case (k)
      0: e.timebase_ovf = 1'b1;
      1: e.timer_a_ovf = 1'b1;
      2: e.timer_b_ovf = 1'b1;
      3: e.spi_byte_done = 2'h1;
      4: e.spi_byte_done = 2'h2;
      5: e.i2c_addr_match = 2'h2;
      default: e.i2c_byte_done = 2'h1;
    endcase
    return e;
  endfunction : evk
  task automatic s_each;
    for (int k = 0; k < 7; k++)
    begin
      wr(k > 4 ? 10'h3FF : 10'h3FC);
      pcb = pc;
      fire(evk(k), 5'h00, 5'h00);
      take(vt[k], pcb, k > 4 ? 9 - k : k);
      pop(pcb);
    end
  endtask : s_each
  task automatic s_prio;
    wr(10'h1FC);
    fire('0, 5'h1F, 5'h00);
    quiet();
    wr(10'h200);
    quiet();
    chk({flags, wake}, 6'h3F);
    for (int k = 0; k < 5; k++)
    begin
      wr(10'h3FC);
      pcb = pc;
      take(vt[k], pcb, k);
      chk(flags >> (k + 1), 5'h1F >> (k + 1));
      pop(pcb);
    end
  endtask : s_prio
  task automatic s_stack;
    wr(10'h3FC);
    pcb = pc;
    fire('0, 5'h01, 5'h00);
    take(VEC_TIMEBASE, pcb, 0);
    wr(10'h3FC);
    fire('0, 5'h02, 5'h00);
    take(VEC_TIMER_A, VEC_TIMEBASE, 1);
    wr(10'h3FC);
    fire('0, 5'h04, 5'h00);
    quiet();
    pop(VEC_TIMEBASE);
    take(VEC_TIMER_B, VEC_TIMEBASE, 2);
    pop(VEC_TIMEBASE);
    pop(pcb);
    fire('0, 5'h18, 5'h00);
    fire('0, 5'h00, 5'h18);
    tick();
    tick();
    chk({flags, wake}, 6'h00);
  endtask : s_stack
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick();
    chk({flags, gie, wake, ent.take, ld}, 9'h000);
    s_each();
    s_prio();
    s_stack();
    results();
  end
  initial
  begin
    #(5000 * 5);
    failures++;
    results();
  end
endmodule : viu_top_bench
`default_nettype wire
